//--- design/eeecc_cfg_if.sv
// Interface: decoded EEE control fields passed from the register file to the datapath
`timescale 1ns/10ps
`default_nettype none
interface eeecc_cfg_if;
   logic       lpiReqSel;
   logic [1:0] pinSel;
   logic       advBypass;
   logic       capEnable;
   logic       advBit;
   logic       partnerAbility;
   modport regs (output lpiReqSel, output pinSel, output advBypass, output capEnable,
                 output advBit, input partnerAbility);
   modport path (input lpiReqSel, input pinSel, input advBypass, input capEnable,
                 input advBit, output partnerAbility);
endinterface
`default_nettype wire

//--- design/eeecc_lpi_path.sv
// Module: LPI request pin selection and advertised-ability resolution
`timescale 1ns/10ps
`default_nettype none
module eeecc_lpi_path (
   input  wire logic  clk,
   input  wire logic  srst,
   eeecc_cfg_if.path  cfg,
   input  wire logic  intPdPinIn,
   input  wire logic  colGpioPinIn,
   input  wire logic  lpRx100Eee,
   input  wire logic  lpPageValid,
   output logic       lpiRequest,
   output logic       advertiseEee
);
   // ==========================================
   // Pin select
   wire txErSeen = (cfg.pinSel == eeecc_pkg::PINSEL_INTPD)   ? intPdPinIn   :
                   (cfg.pinSel == eeecc_pkg::PINSEL_COLGPIO) ? colGpioPinIn :
                   1'b0; // R2
   wire next_lpiRequest = cfg.lpiReqSel & cfg.capEnable & txErSeen; // R1
   // ==========================================
   // Advertisement source
   wire next_advertise = cfg.advBypass ? cfg.capEnable               // R3
                                       : (cfg.capEnable & cfg.advBit); // R4 R8 R9
   logic lpAbility;
   always_ff @(posedge clk) begin
      if (srst) begin
         lpiRequest   <= 1'b0;
         advertiseEee <= 1'b0;
         lpAbility    <= 1'b0;
      end else begin
         lpiRequest   <= next_lpiRequest;
         advertiseEee <= next_advertise;
         if (lpPageValid) begin
            lpAbility <= lpRx100Eee;
         end
      end
   end
   assign cfg.partnerAbility = lpAbility; // R12
   property p_pin_route;
      @(posedge clk) disable iff (srst)
         (cfg.pinSel == 2'h3 || cfg.pinSel == 2'h0) |=> !lpiRequest;
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("LPI request, no pin"); // R2
endmodule
`default_nettype wire

//--- design/eeecc_pkg.sv
// Package: register map, field positions and reset values of the EEE configuration block
package eeecc_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 16;
   localparam logic [15:0] OFF_CFG_LO      = 16'h04d0;
   localparam logic [15:0] OFF_CFG_HI      = 16'h04d1;
   localparam logic [15:0] OFF_EEE_CAP     = 16'h3014;
   localparam logic [15:0] OFF_EEE_ADV     = 16'h703c;
   localparam logic [15:0] OFF_EEE_LP      = 16'h703d;
   localparam logic [15:0] OFF_STATUS      = 16'h04d2;
   localparam int          LO_LPI_REQ_BIT  = 14;
   localparam int          LO_PINSEL_LSB   = 5;
   localparam int          HI_BYPASS_BIT   = 3;
   localparam int          HI_NPDIS_BIT    = 2;
   localparam int          HI_RXSHUT_BIT   = 1;
   localparam int          HI_CAPEN_BIT    = 0;
   localparam int          ADV_100_BIT     = 1;
   localparam int          LP_100_BIT      = 1;
   localparam int          CAP_100_BIT     = 1;
   localparam logic [15:0] LO_RW_MASK      = 16'h4060;
   localparam logic [15:0] LO_RESET        = 16'h0302;
   localparam logic [15:0] HI_RW_MASK      = 16'hffff;
   localparam logic [15:0] HI_RESET_NOSTRAP = 16'h018a;
   localparam logic [15:0] EEE_CAP_VALUE   = 16'h0002;
   localparam logic [1:0]  PINSEL_INTPD    = 2'h1;
   localparam logic [1:0]  PINSEL_COLGPIO  = 2'h2;
endpackage

//--- design/eeecc_top.sv
// Module: EEE configuration registers and control outputs
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] With the LPI-request select bit set, a high transmit-error input asks for low-power idle.
// [R2] A two-bit field routes transmit error from interrupt/powerdown (01), collision/GPIO (10) or none.
// [R3] With advertise bypass set (reset), advertised EEE follows the capability-enable bit.
// [R4] With bypass clear, advertised EEE follows the standard advertisement register bit, gated by capability enable.
// [R5] The next-page-disable bit refuses EEE next pages when set and accepts them at reset.
// [R6] The receive-shutdown bit (reset one) powers the analog receive path down in LPI quiet.
// [R7] The strap-reset capability-enable bit declares EEE support when set and none when clear.
// [R8] With capability on, negotiation follows the advertisement and partner ability registers.
// [R9] With capability off, the capability and both negotiation registers are ignored.
// [R10] Software turns EEE off by writing zero to capability enable whatever the strap.
// [R11] The advertisement register holds a strap-reset bit advertising 100BASE-TX EEE.
// [R12] A read-only bit reports whether the partner advertised 100BASE-TX EEE.
// [R13] Software keeps reserved fields at their reset values by read-modify-write.
module eeecc_top (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [15:0] regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [15:0] regRdData,
   input  wire logic        strapEeeEnable,
   input  wire logic        intPdPinIn,
   input  wire logic        colGpioPinIn,
   input  wire logic        lpRx100Eee,
   input  wire logic        lpPageValid,
   input  wire logic        lpiQuiet,
   input  wire logic        eeeNextPageIn,
   output logic             lpiRequest,
   output logic             advertiseEee,
   output logic             rxAnalogPowerDown,
   output logic             acceptEeeNextPage,
   output logic             eeeEnabled
);
   // ==========================================
   // Registers
   logic [15:0] cfgLo;
   logic [15:0] cfgHi;
   logic        adv100;
   logic        strapPending;
   eeecc_cfg_if cfg ();

   function automatic logic isReg(input logic [15:0] addr, input logic [15:0] off);
      return addr == off;
   endfunction
   wire hitLo  = isReg(regAddr, eeecc_pkg::OFF_CFG_LO);
   wire hitHi  = isReg(regAddr, eeecc_pkg::OFF_CFG_HI);
   wire hitAdv = isReg(regAddr, eeecc_pkg::OFF_EEE_ADV);
   wire hitLp  = isReg(regAddr, eeecc_pkg::OFF_EEE_LP);
   wire hitCap = isReg(regAddr, eeecc_pkg::OFF_EEE_CAP);
   wire wrLo   = regWrite & hitLo;
   wire wrHi   = regWrite & hitHi;
   wire wrAdv  = regWrite & hitAdv;
   wire [15:0] next_cfgLo = (cfgLo & ~eeecc_pkg::LO_RW_MASK) |
                            (regWrData & eeecc_pkg::LO_RW_MASK);
   // Strap sampled the cycle after reset release, unless software writes the high word in that same cycle
   wire strapLoad = strapPending & ~wrHi;

   always_ff @(posedge clk) begin
      if (srst) begin
         cfgLo        <= eeecc_pkg::LO_RESET;
         cfgHi        <= eeecc_pkg::HI_RESET_NOSTRAP;
         adv100       <= 1'b0;
         strapPending <= 1'b1;
      end else begin
         strapPending <= 1'b0;
         if (wrLo) begin
            cfgLo <= next_cfgLo; // R1 R2
         end
         if (wrHi) begin
            cfgHi <= regWrData; // R10
         end else if (strapLoad) begin
            cfgHi[eeecc_pkg::HI_CAPEN_BIT] <= strapEeeEnable; // R7
         end
         if (wrAdv) begin
            adv100 <= regWrData[eeecc_pkg::ADV_100_BIT]; // R11
         end else if (strapPending) begin
            adv100 <= strapEeeEnable; // R11
         end
      end
   end

   assign cfg.lpiReqSel = cfgLo[eeecc_pkg::LO_LPI_REQ_BIT];
   assign cfg.pinSel    = cfgLo[eeecc_pkg::LO_PINSEL_LSB +: 2];
   assign cfg.advBypass = cfgHi[eeecc_pkg::HI_BYPASS_BIT];
   assign cfg.capEnable = cfgHi[eeecc_pkg::HI_CAPEN_BIT];
   assign cfg.advBit    = adv100;

   eeecc_lpi_path u_path (
      .clk          (clk),
      .srst         (srst),
      .cfg          (cfg),
      .intPdPinIn   (intPdPinIn),
      .colGpioPinIn (colGpioPinIn),
      .lpRx100Eee   (lpRx100Eee),
      .lpPageValid  (lpPageValid),
      .lpiRequest   (lpiRequest),
      .advertiseEee (advertiseEee)
   );

   // ==========================================
   // Control outputs
   wire capOn = cfgHi[eeecc_pkg::HI_CAPEN_BIT];
   always_ff @(posedge clk) begin
      if (srst) begin
         rxAnalogPowerDown <= 1'b0;
         acceptEeeNextPage <= 1'b0;
         eeeEnabled        <= 1'b0;
      end else begin
         rxAnalogPowerDown <= capOn & lpiQuiet & cfgHi[eeecc_pkg::HI_RXSHUT_BIT]; // R6
         acceptEeeNextPage <= capOn & eeeNextPageIn
                              & ~cfgHi[eeecc_pkg::HI_NPDIS_BIT]; // R5
         eeeEnabled        <= capOn; // R7 R9
      end
   end

   // ==========================================
   // Read port, data valid the cycle after the strobe
   // Capability and partner registers read zero when EEE is off
   wire [15:0] capWord = capOn ? eeecc_pkg::EEE_CAP_VALUE : 16'h0000; // R9
   wire [15:0] advWord = {14'h0000, adv100, 1'b0};
   wire [15:0] lpWord  = {14'h0000, cfg.partnerAbility & capOn, 1'b0}; // R12
   wire [15:0] rdMux   = hitLo  ? cfgLo :
                         hitHi  ? cfgHi :
                         hitAdv ? advWord :
                         hitLp  ? lpWord :
                         hitCap ? capWord :
                         16'h0000;
   always_ff @(posedge clk) begin
      if (srst) begin
         regRdData <= 16'h0000;
      end else begin
         regRdData <= regRead ? rdMux : 16'h0000;
      end
   end

   // ==========================================
   // Checks
   property p_lpi_req;
      @(posedge clk) disable iff (srst)
         (!cfg.lpiReqSel) |=> !lpiRequest;
   endproperty
   a_lpi_req: assert property (p_lpi_req) else $error("LPI request while select clear"); // R1
   property p_pin_int;
      @(posedge clk) disable iff (srst)
         (cfg.lpiReqSel && capOn && cfg.pinSel == 2'h1) |=> (lpiRequest == $past(intPdPinIn));
   endproperty
   a_pin_int: assert property (p_pin_int) else $error("Pin 01 not routed"); // R2
   property p_bypass;
      @(posedge clk) disable iff (srst)
         cfg.advBypass |=> (advertiseEee == $past(capOn));
   endproperty
   a_bypass: assert property (p_bypass) else $error("Bypass advert wrong"); // R3
   property p_std_adv;
      @(posedge clk) disable iff (srst)
         !cfg.advBypass |=> (advertiseEee == $past(capOn & adv100));
   endproperty
   a_std_adv: assert property (p_std_adv) else $error("Standard advert wrong"); // R4
   property p_np;
      @(posedge clk) disable iff (srst)
         cfgHi[eeecc_pkg::HI_NPDIS_BIT] |=> !acceptEeeNextPage;
   endproperty
   a_np: assert property (p_np) else $error("Next page accepted while disabled"); // R5
   property p_rxshut;
      @(posedge clk) disable iff (srst)
         (!cfgHi[eeecc_pkg::HI_RXSHUT_BIT]) |=> !rxAnalogPowerDown;
   endproperty
   a_rxshut: assert property (p_rxshut) else $error("RX shutdown while disabled"); // R6
   sequence s_write_hi0;
      wrHi && !regWrData[eeecc_pkg::HI_CAPEN_BIT];
   endsequence
   property p_cap_off;
      @(posedge clk) disable iff (srst)
         s_write_hi0 |=> !capOn ##1 !eeeEnabled;
   endproperty
   a_cap_off: assert property (p_cap_off) else $error("EEE not disabled by write"); // R7
   property p_ignore;
      @(posedge clk) disable iff (srst)
         (regRead && !capOn && regAddr == eeecc_pkg::OFF_EEE_CAP) |=> regRdData == 16'h0000;
   endproperty
   a_ignore: assert property (p_ignore) else $error("Capability visible while off"); // R9

   // ==========================================
   // Checks: register writes and strap load
   sequence s_write_hi1;
      wrHi && regWrData[eeecc_pkg::HI_CAPEN_BIT];
   endsequence
   sequence s_enable_seen;
      capOn ##1 eeeEnabled;
   endsequence
   property p_cap_on;
      @(posedge clk) disable iff (srst)
         s_write_hi1 |=> s_enable_seen;
   endproperty
   a_cap_on: assert property (p_cap_on) else $error("EEE not enabled by write"); // R7
   property p_strap_cap;
      @(posedge clk) disable iff (srst)
         (strapPending && !wrHi) |=> (capOn == $past(strapEeeEnable));
   endproperty
   a_strap_cap: assert property (p_strap_cap) else $error("Strap not loaded"); // R7
   property p_strap_adv;
      @(posedge clk) disable iff (srst)
         (strapPending && !wrAdv) |=> (adv100 == $past(strapEeeEnable));
   endproperty
   a_strap_adv: assert property (p_strap_adv) else $error("Advert strap not loaded"); // R11
   property p_lo_write;
      @(posedge clk) disable iff (srst)
         wrLo |=> ((cfgLo & eeecc_pkg::LO_RW_MASK) ==
                   ($past(regWrData) & eeecc_pkg::LO_RW_MASK));
   endproperty
   a_lo_write: assert property (p_lo_write) else $error("Control bits not written"); // R1 R2
   property p_lo_fixed;
      @(posedge clk) disable iff (srst)
         wrLo |=> ((cfgLo & ~eeecc_pkg::LO_RW_MASK) ==
                   (eeecc_pkg::LO_RESET & ~eeecc_pkg::LO_RW_MASK));
   endproperty
   a_lo_fixed: assert property (p_lo_fixed) else $error("Read-only bits written"); // R1 R2
   property p_hi_write;
      @(posedge clk) disable iff (srst)
         wrHi |=> (cfgHi == $past(regWrData));
   endproperty
   a_hi_write: assert property (p_hi_write) else $error("Config word not written"); // R10
   property p_hi_hold;
      @(posedge clk) disable iff (srst)
         (!wrHi && !strapPending) |=> $stable(cfgHi);
   endproperty
   a_hi_hold: assert property (p_hi_hold) else $error("Config word changed"); // R7
   property p_adv_write;
      @(posedge clk) disable iff (srst)
         wrAdv |=> (adv100 == $past(regWrData[eeecc_pkg::ADV_100_BIT]));
   endproperty
   a_adv_write: assert property (p_adv_write) else $error("Advert bit not written"); // R11

   // ==========================================
   // Checks: control outputs
   property p_pin_col;
      @(posedge clk) disable iff (srst)
         (cfg.lpiReqSel && capOn && cfg.pinSel == eeecc_pkg::PINSEL_COLGPIO) |=>
            (lpiRequest == $past(colGpioPinIn));
   endproperty
   a_pin_col: assert property (p_pin_col) else $error("Pin 10 not routed"); // R2
   property p_lpi_capoff;
      @(posedge clk) disable iff (srst)
         !capOn |=> !lpiRequest;
   endproperty
   a_lpi_capoff: assert property (p_lpi_capoff) else $error("LPI request, EEE off"); // R1 R9
   property p_adv_off;
      @(posedge clk) disable iff (srst)
         !capOn |=> !advertiseEee;
   endproperty
   a_adv_off: assert property (p_adv_off) else $error("Advert while EEE off"); // R7 R9
   property p_adv_cap_on;
      @(posedge clk) disable iff (srst)
         (capOn && cfg.advBypass) |=> advertiseEee;
   endproperty
   a_adv_cap_on: assert property (p_adv_cap_on) else $error("Bypass advert missing"); // R3
   property p_np_on;
      @(posedge clk) disable iff (srst)
         (capOn && eeeNextPageIn && !cfgHi[eeecc_pkg::HI_NPDIS_BIT]) |=> acceptEeeNextPage;
   endproperty
   a_np_on: assert property (p_np_on) else $error("Next page refused"); // R5
   property p_np_capoff;
      @(posedge clk) disable iff (srst)
         !capOn |=> !acceptEeeNextPage;
   endproperty
   a_np_capoff: assert property (p_np_capoff) else $error("Next page, EEE off"); // R9
   property p_rx_on;
      @(posedge clk) disable iff (srst)
         (capOn && lpiQuiet && cfgHi[eeecc_pkg::HI_RXSHUT_BIT]) |=> rxAnalogPowerDown;
   endproperty
   a_rx_on: assert property (p_rx_on) else $error("RX path not shut in quiet"); // R6
   property p_rx_awake;
      @(posedge clk) disable iff (srst)
         !lpiQuiet |=> !rxAnalogPowerDown;
   endproperty
   a_rx_awake: assert property (p_rx_awake) else $error("RX shut outside quiet"); // R6
   property p_rx_capoff;
      @(posedge clk) disable iff (srst)
         !capOn |=> !rxAnalogPowerDown;
   endproperty
   a_rx_capoff: assert property (p_rx_capoff) else $error("RX shut, EEE off"); // R9
   property p_enabled;
      @(posedge clk) disable iff (srst)
         capOn |=> eeeEnabled;
   endproperty
   a_enabled: assert property (p_enabled) else $error("Enable not shown"); // R7
   property p_disabled;
      @(posedge clk) disable iff (srst)
         !capOn |=> !eeeEnabled;
   endproperty
   a_disabled: assert property (p_disabled) else $error("Disable not shown"); // R7

   // ==========================================
   // Checks: partner ability and read port
   property p_lp_capture;
      @(posedge clk) disable iff (srst)
         lpPageValid |=> (cfg.partnerAbility == $past(lpRx100Eee));
   endproperty
   a_lp_capture: assert property (p_lp_capture) else $error("Partner bit not taken"); // R12
   property p_lp_hold;
      @(posedge clk) disable iff (srst)
         !lpPageValid |=> $stable(cfg.partnerAbility);
   endproperty
   a_lp_hold: assert property (p_lp_hold) else $error("Partner bit changed"); // R12
   property p_rd_idle;
      @(posedge clk) disable iff (srst)
         !regRead |=> (regRdData == 16'h0000);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("Read data without strobe"); // R13
   property p_rd_lo;
      @(posedge clk) disable iff (srst)
         (regRead && hitLo) |=> (regRdData == $past(cfgLo));
   endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("Low word read wrong"); // R1 R2
   property p_rd_hi;
      @(posedge clk) disable iff (srst)
         (regRead && hitHi) |=> (regRdData == $past(cfgHi));
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("High word read wrong"); // R3 R6 R7
   property p_rd_adv;
      @(posedge clk) disable iff (srst)
         (regRead && hitAdv) |=> (regRdData == {14'h0000, $past(adv100), 1'b0});
   endproperty
   a_rd_adv: assert property (p_rd_adv) else $error("Advert read wrong"); // R11
   property p_rd_lp;
      @(posedge clk) disable iff (srst)
         (regRead && hitLp) |=>
            (regRdData == {14'h0000, $past(cfg.partnerAbility & capOn), 1'b0});
   endproperty
   a_rd_lp: assert property (p_rd_lp) else $error("Partner read wrong"); // R9 R12
   property p_rd_cap_on;
      @(posedge clk) disable iff (srst)
         (regRead && hitCap && capOn) |=> (regRdData == eeecc_pkg::EEE_CAP_VALUE);
   endproperty
   a_rd_cap_on: assert property (p_rd_cap_on) else $error("Capability read wrong"); // R8
   property p_rd_unmapped;
      @(posedge clk) disable iff (srst)
         (regRead && !(hitLo || hitHi || hitAdv || hitLp || hitCap)) |=>
            (regRdData == 16'h0000);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("Unmapped read not zero"); // R13
endmodule
`default_nettype wire

//--- verif/eeecc_mac_model.sv
// MAC-side model: drives transmit error onto the chosen shared pin
`timescale 1ns/10ps
`default_nettype none
module eeecc_mac_model (
   input  wire logic       clk,
   input  wire logic       txErr,
   input  wire logic [1:0] pinCode,
   output logic            intPdPinIn,
   output logic            colGpioPinIn
);
   logic toggle;
   // Unselected pin toggles, so a wrong route cannot pass by luck
   always_ff @(posedge clk) begin
      toggle <= (toggle === 1'b1) ? 1'b0 : 1'b1;
   end
   assign intPdPinIn   = (pinCode == eeecc_pkg::PINSEL_INTPD) ? txErr : toggle;
   assign colGpioPinIn = (pinCode == eeecc_pkg::PINSEL_COLGPIO) ? txErr : toggle;
endmodule
`default_nettype wire

//--- verif/tb_eeecc_top.sv
// Testbench: register access and control outputs of the EEE configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_eeecc_top;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [15:0] regRdData;
   logic        strapEeeEnable = 1'b1;
   logic        lpRx100Eee = 1'b0;
   logic        lpPageValid = 1'b0;
   logic        lpiQuiet = 1'b0;
   logic        eeeNextPageIn = 1'b0;
   logic        txErr = 1'b0;
   logic [1:0]  pinCode = 2'h0;
   logic        intPdPinIn, colGpioPinIn, lpiRequest, advertiseEee;
   logic        rxAnalogPowerDown, acceptEeeNextPage, eeeEnabled;
   int          failures = 0;
   int          checks = 0;
   int          cycles = 0;

   eeecc_top eeecc_top_i (.clk, .srst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
      .strapEeeEnable, .intPdPinIn, .colGpioPinIn, .lpRx100Eee, .lpPageValid, .lpiQuiet,
      .eeeNextPageIn, .lpiRequest, .advertiseEee, .rxAnalogPowerDown, .acceptEeeNextPage,
      .eeeEnabled);
   eeecc_mac_model eeecc_mac_model_i (.clk, .txErr, .pinCode, .intPdPinIn, .colGpioPinIn);

   always #5 clk = ~clk;
   // Whole run needs about a hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         give_verdict();
      end
   end

   // ==========================
   // Access and compare tasks
   task automatic give_verdict();
      if (failures == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite  <= 1'b0;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 cmp16(regRdData, exp);
   endtask
   // Order: lpiRequest, advertise, rx power down, accept next page, enabled
   task automatic chkOut(input logic [4:0] exp);
      repeat (2) @(posedge clk);
      #1 cmp16({11'h000, lpiRequest, advertiseEee, rxAnalogPowerDown, acceptEeeNextPage,
                eeeEnabled}, {11'h000, exp});
   endtask

   // ==========================
   // Scenarios
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rdchk(eeecc_pkg::OFF_CFG_LO, eeecc_pkg::LO_RESET);
      rdchk(eeecc_pkg::OFF_CFG_HI, eeecc_pkg::HI_RESET_NOSTRAP | 16'h0001);
      rdchk(eeecc_pkg::OFF_EEE_ADV, 16'h0002);
      rdchk(eeecc_pkg::OFF_EEE_CAP, eeecc_pkg::EEE_CAP_VALUE);
      rdchk(eeecc_pkg::OFF_EEE_LP, 16'h0000);
      rdchk(16'h04d3, 16'h0000);
      chkOut(5'b01001);
      wr(eeecc_pkg::OFF_CFG_LO, 16'hffff);
      txErr <= 1'b1;
      rdchk(eeecc_pkg::OFF_CFG_LO, eeecc_pkg::LO_RESET | eeecc_pkg::LO_RW_MASK);
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 4; c++) begin
            wr(eeecc_pkg::OFF_CFG_LO, {1'b0, s[0], 7'h00, c[1:0], 5'h00});
            pinCode <= c[1:0];
            chkOut({s[0] && (c == 1 || c == 2), 4'b1001});
         end
      end
      wr(eeecc_pkg::OFF_CFG_LO, 16'h4020);
      pinCode       <= 2'h1;
      lpiQuiet      <= 1'b1;
      eeeNextPageIn <= 1'b1;
      wr(eeecc_pkg::OFF_CFG_HI, 16'h0180);
      chkOut(5'b00000);
      rdchk(eeecc_pkg::OFF_EEE_CAP, 16'h0000);
      @(posedge clk);
      lpRx100Eee  <= 1'b1;
      lpPageValid <= 1'b1;
      @(posedge clk);
      lpPageValid <= 1'b0;
      rdchk(eeecc_pkg::OFF_EEE_LP, 16'h0000);
      wr(eeecc_pkg::OFF_CFG_HI, 16'h0183);
      chkOut(5'b11111);
      rdchk(eeecc_pkg::OFF_EEE_LP, 16'h0002);
      wr(eeecc_pkg::OFF_EEE_ADV, 16'h0000);
      chkOut(5'b10111);
      rdchk(eeecc_pkg::OFF_EEE_ADV, 16'h0000);
      wr(eeecc_pkg::OFF_CFG_HI, 16'h0189);
      chkOut(5'b11011);
      wr(eeecc_pkg::OFF_CFG_HI, 16'h018d);
      chkOut(5'b11001);
      wr(eeecc_pkg::OFF_EEE_CAP, 16'hffff);
      rdchk(eeecc_pkg::OFF_EEE_CAP, eeecc_pkg::EEE_CAP_VALUE);
      rdchk(eeecc_pkg::OFF_CFG_HI, 16'h018d);
      give_verdict();
   end
endmodule
`default_nettype wire
